// file: verilog/catc_pkg.sv
// constants, types and state encodings of the capture trigger control
package catc_pkg;
    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 8;
    localparam int unsigned US_IN_NS        = 1_000;
    localparam int unsigned CYC_PER_US      = (US_IN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MEAS_WINDOW_S   = 1;
    localparam int unsigned MEAS_WINDOW_CYC = CLK_HZ * MEAS_WINDOW_S;
    localparam int CNT_W  = 16;
    localparam int EXP_W  = 24;
    localparam int FPS_W  = 20;
    localparam int LPS_W  = 24;
    localparam int ACC_W  = 28;
    localparam int US_W   = 7;
    localparam int ROW_W  = 12;
    localparam int WIN_W  = 32;
    localparam int PIN_N  = 4;
    localparam int PIN_IW = 2;
    localparam int KIND_N = 2;
    localparam logic [US_W-1:0]  US_LAST   = US_W'(CYC_PER_US - 1);
    localparam logic [ROW_W-1:0] ROWS_LAST = 12'h00F;
    localparam logic [ACC_W-1:0] ACC_WRAP  = ACC_W'(CLK_HZ);
    localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
    localparam logic [EXP_W-1:0] EXP_ZERO  = 24'h000000;

    typedef enum logic [1:0] {CAP_CONTINUOUS, ONE_IMAGE_MODE, BURST_MODE} catc_cap_mode_t;
    typedef enum logic {EXPO_TIMED, PULSE_LENGTH_EXPOSURE} catc_expo_mode_t;
    typedef enum logic [1:0] {AUTO_OFF, AUTO_ONCE, AUTO_CONT} catc_auto_t;
    typedef enum logic [2:0] {
        ORIGIN_SOFTWARE, INPUT_PIN_ZERO, INPUT_PIN_ONE, INPUT_PIN_TWO, INPUT_PIN_THREE
    } catc_origin_t;
    typedef enum logic [1:0] {
        COND_LOW_LEVEL, COND_HIGH_LEVEL, COND_FALL_EDGE, COND_RISE_EDGE
    } catc_cond_t;
    typedef enum logic {KIND_BEGIN, PER_IMAGE_TRIG} catc_kind_t;
    typedef enum logic {SHUTTER_GLOBAL} catc_shutter_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT_BEGIN, ST_ARMED, ST_EXPOSE, ST_READOUT
    } catc_state_t;
endpackage : catc_pkg

// file: verilog/catc_trig_detect.sv
// trigger input synchroniser and condition detector for one trigger kind
`timescale 1ns/10ps
`default_nettype none
module catc_trig_detect (
    input  wire logic                            sys_clk,
    input  wire logic                            rstn,
    input  wire logic                            ce,
    input  wire logic [catc_pkg::PIN_N-1:0]      pins,
    input  wire catc_pkg::catc_origin_t          origin,
    input  wire catc_pkg::catc_cond_t            cond,
    input  wire logic                            sw_cmd,
    output logic                                 trig_evt,
    output logic                                 trig_lvl
);
    import catc_pkg::*;

    typedef struct packed {
        logic [PIN_N-1:0] meta;
        logic [PIN_N-1:0] sync;
        logic [PIN_N-1:0] prev;
    } catc_det_t;

    catc_det_t          st;
    catc_det_t          nxt;
    logic [PIN_IW-1:0]  idx;
    logic               pin_now;
    logic               pin_old;

    always_comb begin
        nxt = st;
        if (ce) begin
            nxt.meta = pins;
            nxt.sync = st.meta;
            nxt.prev = st.sync;
        end
        idx = PIN_IW'(origin - INPUT_PIN_ZERO);
        pin_now = st.sync[idx];
        pin_old = st.prev[idx];
        trig_lvl = 1'b0;
        trig_evt = 1'b0;
        if (origin == ORIGIN_SOFTWARE) begin
            // host command only counts for a software origin
            trig_lvl = sw_cmd;
            trig_evt = sw_cmd & ce;
        end else begin
            case (cond)
                COND_LOW_LEVEL: begin
                    trig_lvl = ~pin_now;
                    trig_evt = ~pin_now & ce;
                end
                COND_HIGH_LEVEL: begin
                    trig_lvl = pin_now;
                    trig_evt = pin_now & ce;
                end
                COND_FALL_EDGE: begin
                    trig_lvl = ~pin_now;
                    trig_evt = pin_old & ~pin_now & ce;
                end
                COND_RISE_EDGE: begin
                    trig_lvl = pin_now;
                    trig_evt = ~pin_old & pin_now & ce;
                end
                default: begin
                    trig_lvl = 1'b0;
                    trig_evt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end

    chk_edge_once:
    assert property (@(posedge sys_clk) disable iff (!rstn)
        (trig_evt && origin != ORIGIN_SOFTWARE && cond inside {COND_FALL_EDGE, COND_RISE_EDGE}
         && $stable(origin) && $stable(cond)) |=> !trig_evt)
        else $error("edge condition gave more than one pulse");
endmodule : catc_trig_detect
`default_nettype wire

// file: verilog/catc_pace_gen.sv
// rate accumulator that ticks at a programmed rate in hertz
`timescale 1ns/10ps
`default_nettype none
module catc_pace_gen #(
    parameter int RATE_W = 20
) (
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              ce,
    input  wire logic              run,
    input  wire logic [RATE_W-1:0] rate,
    output logic                   tick
);
    import catc_pkg::*;

    typedef struct packed {
        logic [ACC_W-1:0] acc;
    } catc_pace_t;

    catc_pace_t     st;
    catc_pace_t     nxt;
    logic [ACC_W:0] sum;

    // adding the rate each cycle and wrapping at the clock rate avoids a divider;
    // a zero rate never ticks
    always_comb begin
        nxt = st;
        tick = 1'b0;
        sum = {1'b0, st.acc} + (ACC_W+1)'(rate);
        if (ce) begin
            if (!run) begin
                nxt.acc = '0;
            end else if (sum >= {1'b0, ACC_WRAP}) begin
                tick = 1'b1;
                nxt.acc = ACC_W'(sum - {1'b0, ACC_WRAP});
            end else begin
                nxt.acc = ACC_W'(sum);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end
endmodule : catc_pace_gen
`default_nettype wire

// file: verilog/catc_ctrl.sv
// capture and trigger control: sequencing, exposure, pacing and rate report
`timescale 1ns/10ps
`default_nettype none
module catc_ctrl #(
    parameter int unsigned MEAS_WINDOW_CYC = catc_pkg::MEAS_WINDOW_CYC
) (
    input  wire logic                              sys_clk,
    input  wire logic                              rstn,
    input  wire logic                              ce,
    input  wire catc_pkg::catc_cap_mode_t          capture_mode_select,
    input  wire logic                              capture_begin_cmd,
    input  wire logic                              capture_end_cmd,
    input  wire logic [catc_pkg::CNT_W-1:0]        burst_image_count,
    input  wire catc_pkg::catc_expo_mode_t         shutter_timing_mode,
    input  wire logic [catc_pkg::EXP_W-1:0]        shutter_duration_us,
    input  wire catc_pkg::catc_auto_t              auto_shutter_mode,
    input  wire logic [catc_pkg::FPS_W-1:0]        requested_frame_pace,
    input  wire logic                              manual_pace_enable,
    input  wire logic [catc_pkg::LPS_W-1:0]        row_capture_pace,
    input  wire logic                              trig_cfg_wr,
    input  wire catc_pkg::catc_kind_t              trig_kind_select,
    input  wire logic                              trig_on_off,
    input  wire catc_pkg::catc_origin_t            trig_origin_select,
    input  wire catc_pkg::catc_cond_t              trig_condition_select,
    input  wire logic                              host_trig_cmd,
    input  wire logic [catc_pkg::PIN_N-1:0]        trig_pins,
    output logic                                   capture_active,
    output logic                                   exposure_active,
    output logic                                   row_strobe,
    output logic                                   image_done,
    output logic [catc_pkg::CNT_W-1:0]             images_left,
    output logic [catc_pkg::FPS_W-1:0]             achieved_frame_pace,
    output catc_pkg::catc_auto_t                   auto_shutter_eff,
    output logic                                   auto_adjust_active,
    output logic [catc_pkg::KIND_N-1:0]            trig_on_status,
    output catc_pkg::catc_shutter_t                readout_shutter_type
);
    import catc_pkg::*;

    localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(MEAS_WINDOW_CYC - 1);

    typedef struct packed {
        catc_state_t               state;
        logic [KIND_N-1:0]         trig_on;
        catc_origin_t [KIND_N-1:0] origin;
        catc_cond_t [KIND_N-1:0]   cond;
        logic [CNT_W-1:0]          left;
        logic [EXP_W-1:0]          exp_cnt;
        logic [US_W-1:0]           us_div;
        logic [ROW_W-1:0]          row_cnt;
        logic                      pace_ok;
        logic                      row_strobe;
        logic                      image_done;
        logic                      once_pend;
        catc_auto_t                auto_prev;
        catc_auto_t                auto_eff;
        logic [FPS_W-1:0]          frames_win;
        logic [FPS_W-1:0]          fps;
        logic [WIN_W-1:0]          win_cnt;
    } catc_ctl_t;

    catc_ctl_t          st;
    catc_ctl_t          nxt;
    logic [KIND_N-1:0]  trig_evt;
    logic [KIND_N-1:0]  trig_lvl;
    logic [KIND_N-1:0]  sw_cmd;
    logic               frame_tick;
    logic               row_tick;
    logic               frame_go;
    logic               start_now;
    logic               done_now;
    logic               last_image;
    logic               width_expo;

    generate
        for (genvar k = 0; k < KIND_N; k++) begin : g_kind
            // host trigger goes to the kind currently selected
            assign sw_cmd[k] = host_trig_cmd & (trig_kind_select == catc_kind_t'(k));
            catc_trig_detect u_det (
                .sys_clk  (sys_clk),
                .rstn     (rstn),
                .ce       (ce),
                .pins     (trig_pins),
                .origin   (st.origin[k]),
                .cond     (st.cond[k]),
                .sw_cmd   (sw_cmd[k]),
                .trig_evt (trig_evt[k]),
                .trig_lvl (trig_lvl[k])
            );
        end
    endgenerate

    catc_pace_gen #(.RATE_W(FPS_W)) u_frame_pace (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .ce      (ce),
        .run     (capture_active),
        .rate    (requested_frame_pace),
        .tick    (frame_tick)
    );

    // row pacing restarts with every readout so row spacing is even
    catc_pace_gen #(.RATE_W(LPS_W)) u_row_pace (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .ce      (ce),
        .run     (st.state == ST_READOUT),
        .rate    (row_capture_pace),
        .tick    (row_tick)
    );

    always_comb begin
        nxt = st;
        start_now = 1'b0;
        done_now = 1'b0;
        frame_go = manual_pace_enable ? st.pace_ok : 1'b1;
        width_expo = (shutter_timing_mode == PULSE_LENGTH_EXPOSURE)
                     && st.trig_on[PER_IMAGE_TRIG];
        last_image = (capture_mode_select == ONE_IMAGE_MODE)
                     || (capture_mode_select == BURST_MODE && st.left <= CNT_ONE);
        if (ce) begin
            nxt.row_strobe = 1'b0;
            nxt.image_done = 1'b0;
            if (trig_cfg_wr) begin
                nxt.trig_on[trig_kind_select] = trig_on_off;
                nxt.origin[trig_kind_select] = trig_origin_select;
                nxt.cond[trig_kind_select] = trig_condition_select;
            end
            case (st.state)
                ST_IDLE: begin
                    nxt.pace_ok = 1'b1;
                    if (capture_begin_cmd) begin
                        if (capture_mode_select == BURST_MODE && burst_image_count != '0) begin
                            nxt.left = burst_image_count;
                        end else begin
                            nxt.left = CNT_ONE;
                        end
                        nxt.state = st.trig_on[KIND_BEGIN] ? ST_WAIT_BEGIN : ST_ARMED;
                    end
                end
                ST_WAIT_BEGIN: begin
                    // switching the kind off releases the wait without a trigger
                    if (!st.trig_on[KIND_BEGIN] || trig_evt[KIND_BEGIN]) begin
                        nxt.state = ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (st.trig_on[PER_IMAGE_TRIG] ? trig_evt[PER_IMAGE_TRIG] : frame_go) begin
                        start_now = 1'b1;
                        nxt.state = ST_EXPOSE;
                        nxt.exp_cnt = shutter_duration_us;
                        nxt.us_div = '0;
                    end
                end
                ST_EXPOSE: begin
                    if (width_expo) begin
                        if (!trig_lvl[PER_IMAGE_TRIG]) begin
                            nxt.state = ST_READOUT;
                            nxt.row_cnt = '0;
                        end
                    end else if (st.exp_cnt == EXP_ZERO) begin
                        nxt.state = ST_READOUT;
                        nxt.row_cnt = '0;
                    end else if (st.us_div == US_LAST) begin
                        nxt.us_div = '0;
                        nxt.exp_cnt = st.exp_cnt - 1'b1;
                    end else begin
                        nxt.us_div = st.us_div + 1'b1;
                    end
                end
                ST_READOUT: begin
                    if (row_tick) begin
                        nxt.row_strobe = 1'b1;
                        if (st.row_cnt == ROWS_LAST) begin
                            done_now = 1'b1;
                            nxt.image_done = 1'b1;
                            nxt.row_cnt = '0;
                            if (capture_mode_select != CAP_CONTINUOUS) begin
                                nxt.left = st.left - 1'b1;
                            end
                            // ending in idle forces the host to begin again
                            nxt.state = last_image ? ST_IDLE : ST_ARMED;
                        end else begin
                            nxt.row_cnt = st.row_cnt + 1'b1;
                        end
                    end
                end
                default: begin
                    nxt.state = ST_IDLE;
                end
            endcase
            if (capture_end_cmd) begin
                nxt.state = ST_IDLE;
            end
            // a pace tick landing on a frame start is kept for the next frame
            if (st.state != ST_IDLE) begin
                nxt.pace_ok = (st.pace_ok && !start_now) || frame_tick;
            end
            nxt.auto_prev = auto_shutter_mode;
            nxt.once_pend = (st.once_pend && !done_now)
                            || (auto_shutter_mode == AUTO_ONCE && st.auto_prev != AUTO_ONCE);
            if (auto_shutter_mode == AUTO_CONT) begin
                nxt.auto_eff = AUTO_CONT;
            end else if (auto_shutter_mode == AUTO_ONCE && nxt.once_pend) begin
                nxt.auto_eff = AUTO_ONCE;
            end else begin
                nxt.auto_eff = AUTO_OFF;
            end
            // images counted per window; a long exposure shows as a lower count
            nxt.frames_win = st.frames_win + FPS_W'(done_now);
            if (st.win_cnt == WIN_LAST) begin
                nxt.fps = nxt.frames_win;
                nxt.frames_win = '0;
                nxt.win_cnt = '0;
            end else begin
                nxt.win_cnt = st.win_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end

    assign capture_active = (st.state != ST_IDLE);
    assign exposure_active = (st.state == ST_EXPOSE);
    assign row_strobe = st.row_strobe;
    assign image_done = st.image_done;
    assign images_left = st.left;
    assign achieved_frame_pace = st.fps;
    assign auto_shutter_eff = st.auto_eff;
    assign auto_adjust_active = (st.auto_eff != AUTO_OFF);
    assign trig_on_status = st.trig_on;
    assign readout_shutter_type = SHUTTER_GLOBAL;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_last_row;
        ce && st.state == ST_READOUT && row_tick && st.row_cnt == ROWS_LAST && !capture_end_cmd;
    endsequence

    sequence s_us_wrap;
        ce && st.state == ST_EXPOSE && !width_expo && st.exp_cnt != EXP_ZERO
        && st.us_div == US_LAST && !capture_end_cmd;
    endsequence

    chk_end_stops:
    assert property ((ce && capture_end_cmd) |=> st.state == ST_IDLE)
        else $error("end command did not stop capture");

    chk_one_image:
    assert property ((s_last_row ##0 capture_mode_select == ONE_IMAGE_MODE)
        |=> st.state == ST_IDLE && st.image_done)
        else $error("one image mode did not stop after one image");

    chk_burst_end:
    assert property ((s_last_row ##0 (capture_mode_select == BURST_MODE && st.left == CNT_ONE))
        |=> st.state == ST_IDLE && st.left == '0)
        else $error("burst did not stop at its count");

    chk_cont_rearm:
    assert property ((s_last_row ##0 capture_mode_select == CAP_CONTINUOUS)
        |=> st.state == ST_ARMED)
        else $error("continuous capture did not rearm");

    chk_begin_trig:
    assert property ((ce && st.state == ST_IDLE && capture_begin_cmd && !capture_end_cmd
        && st.trig_on[KIND_BEGIN]) |=> st.state == ST_WAIT_BEGIN)
        else $error("begin trigger not awaited");

    chk_idle_ignore:
    assert property ((ce && st.state == ST_IDLE && !capture_begin_cmd) |=> st.state == ST_IDLE)
        else $error("trigger acted while stopped");

    chk_us_step:
    assert property (s_us_wrap |=> st.us_div == '0
        && st.exp_cnt == $past(st.exp_cnt) - 1'b1 && st.state == ST_EXPOSE)
        else $error("timed exposure step wrong");

    chk_expo_end:
    assert property ((ce && st.state == ST_EXPOSE && !width_expo && st.exp_cnt == EXP_ZERO)
        |=> st.state inside {ST_READOUT, ST_IDLE})
        else $error("timed exposure overran");

    chk_rows_gate:
    assert property ((ce && st.state != ST_READOUT) |=> !st.row_strobe)
        else $error("row strobe outside readout");

    chk_pace_gate:
    assert property ((ce && st.state == ST_ARMED && !st.trig_on[PER_IMAGE_TRIG]
        && manual_pace_enable && !st.pace_ok) |=> st.state != ST_EXPOSE)
        else $error("frame started before pace tick");
endmodule : catc_ctrl
`default_nettype wire

// file: verification/catc_line_model.sv
// trigger line model: moves the four input pins off the clock edge
`timescale 1ns/10ps
`default_nettype none
module catc_line_model (
    input  wire logic                  sys_clk,
    output logic [catc_pkg::PIN_N-1:0] pins
);
    import catc_pkg::*;
    initial pins = '0;
    task automatic set_pin(int idx, logic lvl);
        @(posedge sys_clk) #3 pins[idx] = lvl;
    endtask : set_pin
endmodule : catc_line_model
`default_nettype wire

// file: verification/tb.sv
// self-checking bench of the capture trigger control
`timescale 1ns/10ps
`default_nettype none
module tb;
    import catc_pkg::*;
    logic sys_clk, rstn, capture_begin_cmd, capture_end_cmd, trig_cfg_wr, trig_on_off;
    logic host_trig_cmd, capture_active, exposure_active, image_done, auto_adjust_active;
    logic manual_pace_enable, row_strobe;
    logic [FPS_W-1:0] requested_frame_pace, achieved_frame_pace;
    logic [CNT_W-1:0] images_left;
    catc_expo_mode_t shutter_timing_mode;
    logic [PIN_N-1:0] trig_pins;
    logic [EXP_W-1:0] shutter_duration_us;
    logic [LPS_W-1:0] row_capture_pace;
    logic [KIND_N-1:0] trig_on_status;
    catc_cap_mode_t capture_mode_select;
    catc_auto_t auto_shutter_mode, auto_shutter_eff;
    catc_kind_t trig_kind_select;
    catc_origin_t trig_origin_select;
    catc_cond_t trig_condition_select;
    catc_shutter_t readout_shutter_type;
    int mismatches, num_checks, n, e, i, r;
    catc_line_model line_u (.sys_clk, .pins(trig_pins));
    catc_ctrl #(.MEAS_WINDOW_CYC(1000)) dut_u (
        .*, .ce(1'b1), .burst_image_count(16'h0003)
    );
    initial forever #4 sys_clk = ~sys_clk;
    task automatic check(logic ok, string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(posedge sys_clk) #1 s = 1'b0;
    endtask : pulse
    task automatic count_hi(ref logic s, input int cyc);
        n = 0;
        repeat (cyc) begin
            @(posedge sys_clk) #1;
            n += int'(s === 1'b1);
        end
    endtask : count_hi
    task automatic run_idle(int bound);
        int k;
        {n, e, r} = '0;
        for (k = 0; capture_active !== 1'b0 && k < bound; k++) begin
            @(posedge sys_clk) #1;
            n += int'(image_done === 1'b1);
            r += int'(row_strobe === 1'b1);
            e += int'(exposure_active === 1'b1);
        end
        check(k < bound, "hang");
        if (k == bound) report_and_stop();
    endtask : run_idle
    task automatic cfg(catc_kind_t k, logic on, catc_origin_t o, catc_cond_t c);
        trig_kind_select = k;
        trig_on_off = on;
        trig_origin_select = o;
        trig_condition_select = c;
        pulse(trig_cfg_wr);
        check(trig_on_status[k] === on, "trig status");
    endtask : cfg
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        {sys_clk, rstn, capture_begin_cmd, capture_end_cmd, trig_cfg_wr, trig_on_off} = '0;
        {host_trig_cmd, manual_pace_enable, mismatches, num_checks} = '0;
        requested_frame_pace = 20'h00000;
        shutter_timing_mode = EXPO_TIMED;
        shutter_duration_us = 24'h000002;
        row_capture_pace = 24'hBEBC20;
        capture_mode_select = ONE_IMAGE_MODE;
        auto_shutter_mode = AUTO_OFF;
        trig_kind_select = KIND_BEGIN;
        trig_origin_select = ORIGIN_SOFTWARE;
        trig_condition_select = COND_RISE_EDGE;
        repeat (20) @(posedge sys_clk);
        #1 rstn = 1'b1;
        check(capture_active === 1'b0 && trig_on_status === 2'h0, "reset");
        check(readout_shutter_type === SHUTTER_GLOBAL, "shutter");
        // once must read off again after the first image, so the second run sees it low
        auto_shutter_mode = AUTO_ONCE;
        for (i = 0; i < 2; i++) begin
            capture_mode_select = i ? BURST_MODE : ONE_IMAGE_MODE;
            pulse(capture_begin_cmd);
            check(capture_active === 1'b1 && auto_adjust_active === !i[0], "go");
            run_idle(5000);
            check(n == 1 + 2 * i && e == n * (2 * CYC_PER_US + 1), "images");
            check(r == n * (int'(ROWS_LAST) + 1) && images_left === '0, "rows");
        end
        auto_shutter_mode = AUTO_CONT;
        @(posedge sys_clk) #1;
        check(auto_shutter_eff === AUTO_CONT && auto_adjust_active === 1'b1, "auto");
        capture_mode_select = CAP_CONTINUOUS;
        cfg(PER_IMAGE_TRIG, 1'b1, ORIGIN_SOFTWARE, COND_RISE_EDGE);
        pulse(host_trig_cmd);
        pulse(capture_begin_cmd);
        count_hi(exposure_active, 100);
        check(n == 0, "queued");
        pulse(host_trig_cmd);
        count_hi(image_done, 800);
        check(n == 1 && capture_active === 1'b1, "per image");
        pulse(capture_end_cmd);
        check(capture_active === 1'b0, "stop");
        cfg(PER_IMAGE_TRIG, 1'b0, ORIGIN_SOFTWARE, COND_RISE_EDGE);
        // free running frames, then paced at one frame per rate window
        pulse(capture_begin_cmd);
        repeat (2100) @(posedge sys_clk) #1;
        check(achieved_frame_pace >= 20'h00002, "free pace");
        pulse(capture_end_cmd);
        {manual_pace_enable, requested_frame_pace} = {1'b1, 20'h1E848};
        pulse(capture_begin_cmd);
        repeat (3100) @(posedge sys_clk) #1;
        check(achieved_frame_pace === 20'h00001, "manual pace");
        pulse(capture_end_cmd);
        manual_pace_enable = 1'b0;
        capture_mode_select = ONE_IMAGE_MODE;
        for (i = 0; i < 4; i++) begin
            line_u.set_pin(i, !i[0]);
            cfg(KIND_BEGIN, 1'b1, catc_origin_t'(i + 1), catc_cond_t'(i));
            pulse(capture_begin_cmd);
            pulse(host_trig_cmd);
            count_hi(exposure_active, 30);
            check(n == 0 && capture_active === 1'b1, "waiting");
            line_u.set_pin(i, i[0]);
            run_idle(3000);
            check(n == 1, "pin trig");
        end
        // exposure follows the pin's high time, about 41 cycles
        cfg(KIND_BEGIN, 1'b0, ORIGIN_SOFTWARE, COND_RISE_EDGE);
        cfg(PER_IMAGE_TRIG, 1'b1, INPUT_PIN_ZERO, COND_HIGH_LEVEL);
        shutter_timing_mode = PULSE_LENGTH_EXPOSURE;
        pulse(capture_begin_cmd);
        line_u.set_pin(0, 1'b1);
        count_hi(exposure_active, 40);
        i = n;
        line_u.set_pin(0, 1'b0);
        run_idle(1000);
        check(n == 1 && i + e >= 36 && i + e <= 42, "pulse length");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
